// ---- hw/lpcpu_core.sv ----
/*
  16-bit core with sleep-level clock controller and an AXI4-Lite port.
  Assumes memory and peripherals answer reads combinationally in the same
  cycle, and that the clock outputs feed the main, subsystem and auxiliary
  trees.
*/
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lpcpu_consts.svh"
module lpcpu_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Memory and peripheral bus
  output lpcpu_pkg::lpcpu_mem_req_t o_mem,
  input wire logic [15:0] i_mem_rdata,
  // Interrupt request
  input wire logic i_irq,
  input wire logic [15:0] i_irq_vec,
  output logic o_irq_ack,
  // Clock and oscillator control
  output logic o_main_clk,
  output logic o_subsystem_clock,
  output logic o_aux_clk,
  output logic o_dcgen_en,
  output logic o_xtal_en,
  output lpcpu_pkg::lpcpu_level_t o_level,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [15:0] core_regs_reg [16];
  lpcpu_pkg::lpcpu_state_t state_reg, state_next;
  logic [15:0] ir_reg, src_val_reg, src_addr_reg, dst_val_reg, dst_addr_reg;
  logic dco_used_reg;
  logic [15:0] program_counter_reg, stack_pointer_reg, status_reg;
  logic [15:0] constant_generator_reg;
  logic [15:0] cur_ir, pc_now, mask, src_op, dst_op, rd_val, res;
  logic [3:0] sreg, dreg, op;
  logic [2:0] f2op;
  logic [1:0] as_m;
  logic is_jmp, is_f1, is_f2, bw, ad, cg, s_ext, s_rd, simple, irq_take;
  logic do_exec, wr_res, upd_fl, jmp_ok, c_n, z_n, n_n, v_n;

  assign program_counter_reg = core_regs_reg[`LP_IDX_PC]; // RULE_02
  assign stack_pointer_reg = core_regs_reg[`LP_IDX_SP];
  assign status_reg = core_regs_reg[`LP_IDX_SR];

  // Decode straight from the bus during fetch so simple ops finish there.
  always_comb begin
    cur_ir = (state_reg == lpcpu_pkg::ST_FETCH) ? i_mem_rdata : ir_reg;
    is_jmp = cur_ir[15:13] == `LP_JMP_PREFIX; // RULE_04
    is_f2 = cur_ir[15:10] == `LP_F2_PREFIX;
    is_f1 = cur_ir[15:14] != 2'h0;
    op = cur_ir[15:12];
    f2op = cur_ir[9:7];
    sreg = is_f2 ? cur_ir[3:0] : cur_ir[11:8];
    dreg = cur_ir[3:0];
    as_m = cur_ir[5:4];
    bw = cur_ir[6]; // RULE_05
    ad = cur_ir[7] & is_f1;
    mask = bw ? `LP_BYTE_MASK : `LP_WORD_MASK;
    pc_now = (state_reg == lpcpu_pkg::ST_FETCH) ? program_counter_reg + `LP_WORD_STEP
                                                : program_counter_reg;
    cg = (sreg == `LP_IDX_CG) | ((sreg == `LP_IDX_SR) & as_m[1]);
    // RULE_03
    s_ext = (as_m == `LP_AS_IDX & sreg != `LP_IDX_CG)
          | (as_m == `LP_AS_INC & sreg == `LP_IDX_PC);
    s_rd = (as_m == `LP_AS_IDX & sreg != `LP_IDX_CG)
         | (as_m[1] & !cg & !(as_m == `LP_AS_INC & sreg == `LP_IDX_PC));
    simple = (is_f1 & !ad & !s_ext & !s_rd)
           | (is_f2 & !f2op[2] & (cg | as_m == `LP_AS_REG)); // RULE_01
    irq_take = i_irq & status_reg[`LP_SR_GIE]
             & (state_reg == lpcpu_pkg::ST_FETCH | state_reg == lpcpu_pkg::ST_SLEEP);
  end

  // Constant generator values and operand selection.
  always_comb begin
    unique case ({sreg == `LP_IDX_SR, as_m})
      3'b110: constant_generator_reg = 16'h0004;
      3'b111: constant_generator_reg = 16'h0008;
      3'b001: constant_generator_reg = 16'h0001;
      3'b010: constant_generator_reg = 16'h0002;
      3'b011: constant_generator_reg = 16'hFFFF;
      default: constant_generator_reg = 16'h0000;
    endcase
    if (cg) begin
      src_op = constant_generator_reg & mask; // RULE_02
    end else if (as_m == `LP_AS_REG) begin
      src_op = (sreg == `LP_IDX_PC ? pc_now : core_regs_reg[sreg]) & mask;
    end else begin
      src_op = src_val_reg & mask;
    end
    if (is_f2) begin
      dst_op = src_op;
    end else if (ad) begin
      dst_op = dst_val_reg & mask;
    end else begin
      dst_op = (dreg == `LP_IDX_PC ? pc_now : core_regs_reg[dreg]) & mask;
    end
  end

  // Arithmetic and logic unit for both operand formats.
  always_comb begin
    logic [16:0] sum;
    logic [15:0] aa;
    logic msb_a, msb_b, msb_r, sub, cin;
    sum = 17'h00000;
    sub = (op == `LP_OP_SUB) | (op == `LP_OP_SUBC) | (op == `LP_OP_CMP);
    aa = (sub ? ~src_op : src_op) & mask;
    cin = (op == `LP_OP_SUB | op == `LP_OP_CMP) ? 1'b1
        : (op == `LP_OP_ADDC | op == `LP_OP_SUBC) ? status_reg[`LP_SR_C] : 1'b0;
    res = 16'h0000;
    wr_res = 1'b1;
    upd_fl = 1'b1;
    c_n = status_reg[`LP_SR_C];
    v_n = 1'b0;
    if (is_f2) begin
      unique case (f2op)
        `LP_F2_RRC: res = ((src_op >> 1) | (bw ? {8'h00, c_n, 7'h00} : {c_n, 15'h0000}));
        `LP_F2_RRA: res = ((src_op >> 1) | (bw ? {8'h00, src_op[7], 7'h00}
                                               : {src_op[15], 15'h0000}));
        `LP_F2_SWPB: res = {src_op[7:0], src_op[15:8]};
        `LP_F2_SXT: res = {{8{src_op[7]}}, src_op[7:0]};
        default: res = src_op;
      endcase
      upd_fl = f2op != `LP_F2_SWPB & !f2op[2];
      c_n = src_op[0];
    end else begin
      sum = {1'b0, dst_op} + {1'b0, aa} + {16'h0000, cin};
      unique case (op)
        `LP_OP_MOV: res = src_op;
        `LP_OP_AND, `LP_OP_BIT: res = src_op & dst_op;
        `LP_OP_BIC: res = dst_op & ~src_op;
        `LP_OP_BIS: res = dst_op | src_op;
        `LP_OP_XOR: res = dst_op ^ src_op;
        default: res = sum[15:0] & mask; // Decimal add runs as binary add.
      endcase
      wr_res = op != `LP_OP_CMP & op != `LP_OP_BIT;
      upd_fl = op != `LP_OP_MOV & op != `LP_OP_BIC & op != `LP_OP_BIS;
      c_n = bw ? sum[8] : sum[16];
    end
    msb_a = bw ? aa[7] : aa[15];
    msb_b = bw ? dst_op[7] : dst_op[15];
    msb_r = bw ? res[7] : res[15];
    z_n = (res & mask) == 16'h0000;
    n_n = msb_r;
    if (!is_f2 & (op == `LP_OP_AND | op == `LP_OP_BIT | op == `LP_OP_XOR)) begin
      c_n = !z_n;
      v_n = (op == `LP_OP_XOR) & msb_a & msb_b;
    end else if (!is_f2 & op != `LP_OP_MOV) begin
      v_n = (msb_a == msb_b) & (msb_r != msb_b);
    end else if (is_f2 & f2op == `LP_F2_SXT) begin
      c_n = !z_n;
    end
  end

  // Jump condition on the current flags.
  always_comb begin
    unique case (cur_ir[12:10])
      3'h0: jmp_ok = !status_reg[`LP_SR_Z];
      3'h1: jmp_ok = status_reg[`LP_SR_Z];
      3'h2: jmp_ok = !status_reg[`LP_SR_C];
      3'h3: jmp_ok = status_reg[`LP_SR_C];
      3'h4: jmp_ok = status_reg[`LP_SR_N];
      3'h5: jmp_ok = status_reg[`LP_SR_N] == status_reg[`LP_SR_V];
      3'h6: jmp_ok = status_reg[`LP_SR_N] != status_reg[`LP_SR_V];
      default: jmp_ok = 1'b1;
    endcase
  end

  // Sequencer: a set halt bit parks the core until an enabled interrupt.
  always_comb begin
    state_next = lpcpu_pkg::ST_FETCH;
    unique case (state_reg)
      lpcpu_pkg::ST_FETCH: begin
        if (irq_take) state_next = lpcpu_pkg::ST_IRQ1; // RULE_08
        else if (status_reg[`LP_SR_CPUOFF]) state_next = lpcpu_pkg::ST_SLEEP; // RULE_10
        else if (is_jmp | simple) state_next = lpcpu_pkg::ST_FETCH;
        else if (is_f2 & f2op == `LP_F2_RETI) state_next = lpcpu_pkg::ST_RETI1;
        else if (s_ext) state_next = lpcpu_pkg::ST_SEXT;
        else if (s_rd) state_next = lpcpu_pkg::ST_SRD;
        else if (ad) state_next = lpcpu_pkg::ST_DEXT;
        else state_next = lpcpu_pkg::ST_EXEC;
      end
      lpcpu_pkg::ST_SEXT: state_next = s_rd ? lpcpu_pkg::ST_SRD
                                     : ad ? lpcpu_pkg::ST_DEXT : lpcpu_pkg::ST_EXEC;
      lpcpu_pkg::ST_SRD: state_next = ad ? lpcpu_pkg::ST_DEXT : lpcpu_pkg::ST_EXEC;
      lpcpu_pkg::ST_DEXT: state_next = lpcpu_pkg::ST_DRD;
      lpcpu_pkg::ST_DRD: state_next = lpcpu_pkg::ST_EXEC;
      lpcpu_pkg::ST_IRQ1: state_next = lpcpu_pkg::ST_IRQ2;
      lpcpu_pkg::ST_IRQ2: state_next = lpcpu_pkg::ST_IRQ3;
      lpcpu_pkg::ST_RETI1: state_next = lpcpu_pkg::ST_RETI2;
      lpcpu_pkg::ST_SLEEP: state_next = irq_take ? lpcpu_pkg::ST_IRQ1 : lpcpu_pkg::ST_SLEEP;
      lpcpu_pkg::ST_EXEC, lpcpu_pkg::ST_IRQ3, lpcpu_pkg::ST_RETI2,
      lpcpu_pkg::ST_BOOT: state_next = lpcpu_pkg::ST_FETCH;
      default: state_next = lpcpu_pkg::ST_BOOT;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) state_reg <= lpcpu_pkg::ST_BOOT;
    else state_reg <= state_next;
  end

  assign do_exec = (state_reg == lpcpu_pkg::ST_EXEC)
                 | (state_reg == lpcpu_pkg::ST_FETCH & state_next == lpcpu_pkg::ST_FETCH
                    & simple & !is_jmp);
  assign o_irq_ack = state_reg == lpcpu_pkg::ST_IRQ3;

  // Bus requests; byte accesses in SRD, DRD and non-push EXEC use one lane, all others both.
  always_comb begin
    logic opnd;
    opnd = 1'b0;
    o_mem = '0;
    unique case (state_reg)
      lpcpu_pkg::ST_BOOT: o_mem.addr = `LP_RESET_VEC;
      lpcpu_pkg::ST_SRD: begin
        o_mem.addr = as_m == `LP_AS_IDX ? src_addr_reg : core_regs_reg[sreg];
        opnd = 1'b1;
      end
      lpcpu_pkg::ST_DRD: begin
        o_mem.addr = dst_addr_reg;
        opnd = 1'b1;
      end
      lpcpu_pkg::ST_EXEC: begin
        if (is_f2 & f2op[2]) begin
          o_mem.addr = stack_pointer_reg - `LP_WORD_STEP; // RULE_06
          o_mem.wdata = f2op == `LP_F2_CALL ? program_counter_reg : src_op;
          o_mem.we = 1'b1;
        end else begin
          o_mem.addr = is_f2 ? src_addr_reg : dst_addr_reg; // RULE_07
          o_mem.wdata = bw ? {res[7:0], res[7:0]} : res;
          o_mem.we = is_f2 ? (!cg & as_m != `LP_AS_REG) : (ad & wr_res);
          opnd = 1'b1;
        end
      end
      lpcpu_pkg::ST_IRQ1, lpcpu_pkg::ST_IRQ2: begin
        o_mem.addr = stack_pointer_reg - `LP_WORD_STEP;
        o_mem.wdata = state_reg == lpcpu_pkg::ST_IRQ1 ? program_counter_reg : status_reg;
        o_mem.we = 1'b1;
      end
      lpcpu_pkg::ST_IRQ3: o_mem.addr = i_irq_vec;
      lpcpu_pkg::ST_RETI1, lpcpu_pkg::ST_RETI2: o_mem.addr = stack_pointer_reg;
      default: o_mem.addr = program_counter_reg;
    endcase
    o_mem.be = (opnd & bw) ? (o_mem.addr[0] ? 2'b10 : 2'b01) : 2'b11;
    rd_val = (opnd & bw) ? {8'h00, o_mem.addr[0] ? i_mem_rdata[15:8] : i_mem_rdata[7:0]}
                         : i_mem_rdata;
  end

  // Operand latches filled while the addressing modes walk the bus.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ir_reg <= 16'h0000;
      src_val_reg <= 16'h0000;
      src_addr_reg <= 16'h0000;
      dst_val_reg <= 16'h0000;
      dst_addr_reg <= 16'h0000;
    end else begin
      if (state_reg == lpcpu_pkg::ST_FETCH) ir_reg <= i_mem_rdata;
      if (state_reg == lpcpu_pkg::ST_SEXT) begin
        if (s_rd) src_addr_reg <= (sreg == `LP_IDX_SR ? 16'h0000 : core_regs_reg[sreg])
                                  + i_mem_rdata;
        else src_val_reg <= i_mem_rdata;
      end
      if (state_reg == lpcpu_pkg::ST_SRD) begin
        src_val_reg <= rd_val;
        src_addr_reg <= o_mem.addr;
      end
      if (state_reg == lpcpu_pkg::ST_DEXT) begin
        dst_addr_reg <= (dreg == `LP_IDX_SR ? 16'h0000 : core_regs_reg[dreg]) + i_mem_rdata;
      end
      if (state_reg == lpcpu_pkg::ST_DRD) dst_val_reg <= rd_val;
    end
  end

  // Register file; later assignments win, so a result aimed at the
  // status register overrides the flag update of the same instruction.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < 16; i++) core_regs_reg[i] <= 16'h0000; // RULE_01
    end else begin
      unique case (state_reg)
        lpcpu_pkg::ST_BOOT: core_regs_reg[`LP_IDX_PC] <= i_mem_rdata;
        lpcpu_pkg::ST_FETCH: begin
          if (!irq_take & !status_reg[`LP_SR_CPUOFF]) begin
            core_regs_reg[`LP_IDX_PC] <= (is_jmp & jmp_ok) // RULE_04
              ? pc_now + {{5{cur_ir[9]}}, cur_ir[9:0], 1'b0} : pc_now;
          end
        end
        lpcpu_pkg::ST_SEXT, lpcpu_pkg::ST_DEXT:
          core_regs_reg[`LP_IDX_PC] <= program_counter_reg + `LP_WORD_STEP;
        lpcpu_pkg::ST_SRD: begin
          if (as_m == `LP_AS_INC) begin // RULE_03
            core_regs_reg[sreg] <= core_regs_reg[sreg]
              + ((bw & sreg != `LP_IDX_SP) ? `LP_BYTE_STEP : `LP_WORD_STEP);
          end
        end
        lpcpu_pkg::ST_EXEC: begin
          if (is_f2 & f2op[2]) begin
            core_regs_reg[`LP_IDX_SP] <= stack_pointer_reg - `LP_WORD_STEP;
            if (f2op == `LP_F2_CALL) core_regs_reg[`LP_IDX_PC] <= src_op; // RULE_06
          end
        end
        lpcpu_pkg::ST_IRQ1: core_regs_reg[`LP_IDX_SP] <= stack_pointer_reg - `LP_WORD_STEP;
        lpcpu_pkg::ST_IRQ2: begin
          core_regs_reg[`LP_IDX_SP] <= stack_pointer_reg - `LP_WORD_STEP;
          core_regs_reg[`LP_IDX_SR] <= status_reg & ~`LP_SR_WAKE_MASK; // RULE_16
        end
        lpcpu_pkg::ST_IRQ3: core_regs_reg[`LP_IDX_PC] <= i_mem_rdata;
        lpcpu_pkg::ST_RETI1: begin
          core_regs_reg[`LP_IDX_SR] <= i_mem_rdata; // RULE_08 RULE_16
          core_regs_reg[`LP_IDX_SP] <= stack_pointer_reg + `LP_WORD_STEP;
        end
        lpcpu_pkg::ST_RETI2: begin
          core_regs_reg[`LP_IDX_PC] <= i_mem_rdata;
          core_regs_reg[`LP_IDX_SP] <= stack_pointer_reg + `LP_WORD_STEP;
        end
        default: ;
      endcase
      if (do_exec & !(is_f2 & f2op[2])) begin
        if (upd_fl) begin
          core_regs_reg[`LP_IDX_SR][`LP_SR_C] <= c_n;
          core_regs_reg[`LP_IDX_SR][`LP_SR_Z] <= z_n;
          core_regs_reg[`LP_IDX_SR][`LP_SR_N] <= n_n;
          core_regs_reg[`LP_IDX_SR][`LP_SR_V] <= v_n;
        end
        if (is_f2 & as_m == `LP_AS_REG & !cg) core_regs_reg[sreg] <= res;
        else if (!is_f2 & !ad & wr_res & dreg != `LP_IDX_CG) core_regs_reg[dreg] <= res;
      end
    end
  end

  // Mode decode from the status bits; registered so gates see a clean level.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_level <= lpcpu_pkg::run_mode;
      o_dcgen_en <= 1'b1;
      o_xtal_en <= 1'b1;
    end else begin
      if (!status_reg[`LP_SR_CPUOFF]) o_level <= lpcpu_pkg::run_mode; // RULE_09
      else if (status_reg[`LP_SR_OSCOFF]) o_level <= lpcpu_pkg::sleep_level_four;
      else if (status_reg[`LP_SR_SCG1]) o_level <= status_reg[`LP_SR_SCG0]
        ? lpcpu_pkg::sleep_level_three : lpcpu_pkg::sleep_level_two;
      else o_level <= status_reg[`LP_SR_SCG0]
        ? lpcpu_pkg::sleep_level_one : lpcpu_pkg::sleep_level_zero;
      // The DC generator drops with SCG0 set, unless the oscillator is used in run mode and SCG1 is clear.
      o_dcgen_en <= !status_reg[`LP_SR_SCG0]
                  | (dco_used_reg & !status_reg[`LP_SR_SCG1]); // RULE_11 RULE_12 RULE_13
      o_xtal_en <= !status_reg[`LP_SR_OSCOFF]; // RULE_14
    end
  end

  // Clock gates: enables change only while the clock is low, so no phase is cut.
  logic [2:0] gate_en, gate_lo_reg, gate_clk;
  assign gate_en[0] = o_level == lpcpu_pkg::run_mode; // RULE_10
  assign gate_en[1] = o_level != lpcpu_pkg::sleep_level_two // RULE_12 RULE_13
                    & o_level != lpcpu_pkg::sleep_level_three
                    & o_level != lpcpu_pkg::sleep_level_four;
  assign gate_en[2] = o_level != lpcpu_pkg::sleep_level_four; // RULE_14
  for (genvar g = 0; g < 3; g++) begin : g_gate
    always_ff @(negedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) gate_lo_reg[g] <= 1'b1;
      else gate_lo_reg[g] <= gate_en[g]; // RULE_15
    end
    assign gate_clk[g] = i_clk & gate_lo_reg[g];
  end
  assign o_main_clk = gate_clk[0];
  assign o_subsystem_clock = gate_clk[1];
  assign o_aux_clk = gate_clk[2];

  // AXI4-Lite: address and data are taken together, one write at a time.
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LP_RESP_OKAY;
      dco_used_reg <= 1'b0;
    end else if (s_axi_awready) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= s_axi_awaddr == `LP_ADDR_CTRL ? `LP_RESP_OKAY : `LP_RESP_SLVERR;
      if (s_axi_awaddr == `LP_ADDR_CTRL & s_axi_wstrb[0]) dco_used_reg <= s_axi_wdata[0];
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read side: one cycle from address to data; unmapped reads give an error.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LP_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `LP_RESP_OKAY;
      unique case (s_axi_araddr)
        `LP_ADDR_CTRL: s_axi_rdata <= {31'h0000_0000, dco_used_reg};
        `LP_ADDR_STAT: s_axi_rdata <= {26'h000_0000, o_xtal_en, o_dcgen_en, 1'b0, o_level};
        `LP_ADDR_PC: s_axi_rdata <= {16'h0000, program_counter_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `LP_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : lpcpu_core
`default_nettype wire

// ---- hw/lpcpu_consts.svh ----
/*
  Constants of the low-power 16-bit core: register indices, status bits,
  opcodes, vectors and register-bus offsets. Definitions only.
  Assumes it is included by bare name from files that need these values.
*/
// Summary of operation
// (RULE_01) The core holds sixteen 16-bit registers and a register-to-register operation finishes in one clock.
// (RULE_02) Registers zero to three are program counter, stack pointer, status and constant generator; the rest are general.
// (RULE_03) All but program-flow work runs as register operations, with seven source and four destination addressing modes.
// (RULE_04) The decoder serves dual-operand, single-operand and relative-jump formats that make up the 51-instruction set.
// (RULE_05) Every instruction works on either a 16-bit word or an 8-bit byte.
// (RULE_06) A call pushes the program counter onto the top of the stack and then loads the operand into the program counter.
// (RULE_07) Peripherals sit on the data, address and control bus and are read and written like memory.
// (RULE_08) One run mode and five sleep levels exist; an interrupt wakes the core and the return restores the sleep level.
// (RULE_09) In run mode all three clocks run and the core executes.
// (RULE_10) Sleep level zero halts the core and gates the main clock while the auxiliary and subsystem clocks run.
// (RULE_11) Sleep level one is level zero plus the oscillator DC generator off unless the oscillator is used in run mode.
// (RULE_12) Sleep level two halts the core and gates main and subsystem clocks, keeping DC generator and auxiliary clock.
// (RULE_13) Sleep level three also turns off the DC generator, leaving only the auxiliary clock.
// (RULE_14) Sleep level four stops the core and all three clocks, the DC generator and the crystal oscillator; here the DC generator stays on with SCG0 clear.
// (RULE_15) Gating a clock on or off never cuts a high or low phase short.
// (RULE_16) The sleep level lives in writable status bits that are saved on interrupt entry and restored on return.
`ifndef LPCPU_CONSTS_SVH
`define LPCPU_CONSTS_SVH

`define LP_IDX_PC 4'h0
`define LP_IDX_SP 4'h1
`define LP_IDX_SR 4'h2
`define LP_IDX_CG 4'h3

`define LP_SR_C 0
`define LP_SR_Z 1
`define LP_SR_N 2
`define LP_SR_GIE 3
`define LP_SR_CPUOFF 4
`define LP_SR_OSCOFF 5
`define LP_SR_SCG0 6
`define LP_SR_SCG1 7
`define LP_SR_V 8
`define LP_SR_WAKE_MASK 16'h00F8

`define LP_RESET_VEC 16'hFFFE
`define LP_WORD_STEP 16'h0002
`define LP_BYTE_STEP 16'h0001
`define LP_BYTE_MASK 16'h00FF
`define LP_WORD_MASK 16'hFFFF

`define LP_F2_PREFIX 6'h04
`define LP_JMP_PREFIX 3'h1
`define LP_OP_MOV 4'h4
`define LP_OP_ADD 4'h5
`define LP_OP_ADDC 4'h6
`define LP_OP_SUBC 4'h7
`define LP_OP_SUB 4'h8
`define LP_OP_CMP 4'h9
`define LP_OP_DADD 4'hA
`define LP_OP_BIT 4'hB
`define LP_OP_BIC 4'hC
`define LP_OP_BIS 4'hD
`define LP_OP_XOR 4'hE
`define LP_OP_AND 4'hF
`define LP_F2_RRC 3'h0
`define LP_F2_SWPB 3'h1
`define LP_F2_RRA 3'h2
`define LP_F2_SXT 3'h3
`define LP_F2_PUSH 3'h4
`define LP_F2_CALL 3'h5
`define LP_F2_RETI 3'h6

`define LP_AS_REG 2'h0
`define LP_AS_IDX 2'h1
`define LP_AS_IND 2'h2
`define LP_AS_INC 2'h3

`define LP_ADDR_CTRL 32'h0000_0000
`define LP_ADDR_STAT 32'h0000_0004
`define LP_ADDR_PC 32'h0000_0008
`define LP_RESP_OKAY 2'h0
`define LP_RESP_SLVERR 2'h2

`endif

// ---- hw/lpcpu_pkg.sv ----
/*
  Types shared by the low-power core: memory request carrier, sequencer
  states and sleep levels. Assumes the constants header is available.
*/
`default_nettype none
package lpcpu_pkg;

  // One request on the memory and peripheral bus.
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic we;
    logic [1:0] be;
  } lpcpu_mem_req_t;

  // Sequencer states, Gray coded along fetch, operands, execute.
  typedef enum logic [3:0] {
    ST_FETCH = 4'h0, ST_SEXT = 4'h1, ST_SRD = 4'h3, ST_DEXT = 4'h2,
    ST_DRD = 4'h6, ST_EXEC = 4'h7, ST_IRQ1 = 4'h5, ST_IRQ2 = 4'h4,
    ST_IRQ3 = 4'hC, ST_RETI1 = 4'hD, ST_RETI2 = 4'hF, ST_SLEEP = 4'hE,
    ST_BOOT = 4'hA
  } lpcpu_state_t;

  // Operating mode as seen from outside.
  typedef enum logic [2:0] {
    run_mode = 3'h0, sleep_level_zero = 3'h1, sleep_level_one = 3'h2,
    sleep_level_two = 3'h3, sleep_level_three = 3'h4, sleep_level_four = 3'h5
  } lpcpu_level_t;

endpackage : lpcpu_pkg
`default_nettype wire

// ---- sim/lpcpu_mem_model.sv ----
/* Zero-wait word memory on the core bus.
   Assumes the bench preloads the program. */
`timescale 1ns/1ps
`default_nettype none
module lpcpu_mem_model (
  input wire logic i_clk,
  input wire lpcpu_pkg::lpcpu_mem_req_t i_req,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [32768];
  // Reads answer at once, as the core has no wait states.
  assign o_rdata = mem[i_req.addr[15:1]];
  // A lane is written only when selected.
  always @(posedge i_clk) begin
    if (i_req.we && i_req.be[0]) mem[i_req.addr[15:1]][7:0] <= i_req.wdata[7:0];
    if (i_req.we && i_req.be[1]) mem[i_req.addr[15:1]][15:8] <= i_req.wdata[15:8];
  end
endmodule : lpcpu_mem_model
`default_nettype wire

// ---- sim/lpcpu_core_checker.sv ----
/* Checks of clock gating, oscillator enables and wake.
   Assumes it is bound to the core. */
`timescale 1ns/1ps
`default_nettype none
module lpcpu_core_checker (
  input wire logic i_clk, i_arst_n, o_irq_ack, o_main_clk, o_subsystem_clock,
  input wire logic o_aux_clk, o_dcgen_en, o_xtal_en,
  input wire lpcpu_pkg::lpcpu_mem_req_t o_mem,
  input wire logic [15:0] i_irq_vec,
  input wire lpcpu_pkg::lpcpu_level_t o_level
);
  // A level is judged once stable, since enables trail it.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_run_osc: assert property (o_level == 3'h0 && $stable(o_level) |-> o_dcgen_en && o_xtal_en)
    else $error("run osc");
  a_lvl3_osc: assert property (o_level == 3'h4 && $stable(o_level) |-> !o_dcgen_en && o_xtal_en)
    else $error("lvl3 osc");
  a_lvl4_osc: assert property (o_level == 3'h5 && $stable(o_level) |-> !o_dcgen_en && !o_xtal_en)
    else $error("lvl4 osc");
  a_wake_vec: assert property (o_irq_ack |-> o_mem.addr == i_irq_vec && !o_mem.we)
    else $error("vector");
  a_lvl0_clk: assert property (@(negedge i_clk) o_level == 3'h1 && $stable(o_level)
    |-> !o_main_clk && o_subsystem_clock && o_aux_clk) else $error("lvl0 clk");
  a_lvl2_clk: assert property (@(negedge i_clk) o_level inside {3'h3, 3'h4}
    && $stable(o_level) |-> !o_main_clk && !o_subsystem_clock && o_aux_clk)
    else $error("lvl2 clk");
  a_lvl4_clk: assert property (@(negedge i_clk) o_level == 3'h5 && $stable(o_level)
    |-> !(o_main_clk || o_subsystem_clock || o_aux_clk)) else $error("lvl4 clk");
  a_run_clk: assert property (@(negedge i_clk) o_level == 3'h0 && $stable(o_level)
    |-> o_main_clk && o_subsystem_clock && o_aux_clk) else $error("run clk");
endmodule : lpcpu_core_checker
bind lpcpu_core lpcpu_core_checker lpcpu_core_checker_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .o_irq_ack(o_irq_ack), .o_main_clk(o_main_clk), .o_subsystem_clock(o_subsystem_clock),
  .o_aux_clk(o_aux_clk), .o_dcgen_en(o_dcgen_en), .o_xtal_en(o_xtal_en), .o_mem(o_mem),
  .i_irq_vec(i_irq_vec), .o_level(o_level));
`default_nettype wire

// ---- sim/testbench.sv ----
/* Bench for the low-power core: levels, wake, registers.
   Assumes the memory model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, irq = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [31:0] aw = 0, wd = 0, ar = 0, rd;
  logic [15:0] rdat;
  logic [1:0] br, rr;
  logic awr, wr, bv, arr, rv, ack, mck, sck, xck, dcg, xt;
  lpcpu_pkg::lpcpu_mem_req_t mreq;
  lpcpu_pkg::lpcpu_level_t lvl;
  int n_mismatch = 0, n_checks = 0;
  // Clock of 100 ns period.
  always #50 clk = ~clk;
  lpcpu_core lpcpu_core_i (.i_clk(clk), .i_arst_n(rst_n), .o_mem(mreq), .i_mem_rdata(rdat),
    .i_irq(irq), .i_irq_vec(16'hFFF0), .o_irq_ack(ack), .o_main_clk(mck), .o_xtal_en(xt),
    .o_subsystem_clock(sck), .o_aux_clk(xck), .o_dcgen_en(dcg), .o_level(lvl),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry));
  lpcpu_mem_model lpcpu_mem_model_i (.i_clk(clk), .i_req(mreq), .o_rdata(rdat));
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr32(input logic [31:0] a, d, output logic [1:0] r);
    @(posedge clk);
    aw <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
    do @(posedge clk); while (!(awr && wr));
    awv <= 0; wv <= 0;
    do @(posedge clk); while (!bv);
    r = br; bry <= 0;
  endtask : wr32
  task automatic rd32(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ar <= a; arv <= 1; rry <= 1;
    do @(posedge clk); while (!arr);
    arv <= 0;
    do @(posedge clk); while (!rv);
    d = rd; r = rr; rry <= 0;
  endtask : rd32
  // Program sets the stack, ORs sr into status, then spins.
  task automatic boot(input logic [15:0] sr);
    logic [15:0] p [5] = '{16'h4031, 16'h0300, 16'hD032, sr, 16'h3FFF};
    @(posedge clk);
    rst_n <= 0;
    for (int i = 0; i < 5; i++) lpcpu_mem_model_i.mem[16'h7800 + i] = p[i];
    lpcpu_mem_model_i.mem[16'h7FFF] = 16'hF000;
    lpcpu_mem_model_i.mem[16'h7FF8] = 16'hF100;
    lpcpu_mem_model_i.mem[16'h7880] = 16'h1300;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (12) @(posedge clk);
  endtask : boot
  // Clocks are seen mid high phase, where a gate shows its enable.
  task automatic t_levels;
    logic [15:0] sr [6] = '{16'h0, 16'h10, 16'h50, 16'h90, 16'hD0, 16'hF0};
    logic [4:0] ex [6] = '{5'h1F, 5'h0F, 5'h0D, 5'h07, 5'h05, 5'h00};
    for (int i = 0; i < 6; i++) begin
      boot(sr[i]);
      #25 chk({mck, sck, xck, dcg, xt}, ex[i]);
      chk(lvl, i);
    end
  endtask : t_levels
  task automatic t_wake;
    boot(16'h18);
    irq <= 1;
    do @(posedge clk); while (!ack);
    irq <= 0;
    @(posedge clk);
    #1 chk(lvl, 0);
    repeat (8) @(posedge clk);
    #1 chk(lvl, 1);
    chk(lpcpu_mem_model_i.mem[16'h017E], 16'h0018);
  endtask : t_wake
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    boot(16'h50);
    wr32(32'h0, 32'h1, r);
    chk(r, 2'h0);
    rd32(32'h4, d, r);
    chk(d[5:0], 6'h32);
    rd32(32'hC, d, r);
    chk(r, 2'h2);
    wr32(32'h4, 32'h0, r);
    chk(r, 2'h2);
  endtask : t_regs
  initial begin
    t_levels();
    t_wake();
    t_regs();
    print_verdict();
  end
  // Watchdog well above the under two hundred cycles needed.
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end
  task automatic print_verdict;
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
endmodule : testbench
`default_nettype wire
